/* File: bench/axil_host.sv */
module axil_host (
	input  wire         i_core_clk,
	input  wire         i_awready,
	input  wire         i_wready,
	input  wire  [1:0]  i_bresp,
	input  wire         i_bvalid,
	input  wire         i_arready,
	input  wire  [31:0] i_rdata,
	input  wire  [1:0]  i_rresp,
	input  wire         i_rvalid,
	output logic [11:0] o_awaddr,
	output logic        o_awvalid,
	output logic [31:0] o_wdata,
	output logic [3:0]  o_wstrb,
	output logic        o_wvalid,
	output logic        o_bready,
	output logic [11:0] o_araddr,
	output logic        o_arvalid,
	output logic        o_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle lines parked low until the first request
	initial begin
		{o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid} = '0;
		{o_bready, o_araddr, o_arvalid, o_rready} = '0;
	end
	// answer ready is held up from the request until the answer
	task automatic wr(input [11:0] a, input [31:0] d, input [3:0] s,
		output [1:0] r);
		@(posedge i_core_clk);
		o_awaddr  <= a;
		o_awvalid <= 1'b1;
		o_wdata   <= d;
		o_wstrb   <= s;
		o_wvalid  <= 1'b1;
		o_bready  <= 1'b1;
		forever begin
			@(posedge i_core_clk);
			if (o_awvalid && i_awready) begin
				o_awvalid <= 1'b0;
				o_awaddr  <= ~a; // released: no stale address
			end
			if (o_wvalid && i_wready) begin
				o_wvalid <= 1'b0;
				o_wdata  <= ~d;
			end
			if (i_bvalid && o_bready) begin
				r = i_bresp;
				o_bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input [11:0] a, output [31:0] d, output [1:0] r);
		@(posedge i_core_clk);
		o_araddr  <= a;
		o_arvalid <= 1'b1;
		o_rready  <= 1'b1;
		forever begin
			@(posedge i_core_clk);
			if (o_arvalid && i_arready) begin
				o_arvalid <= 1'b0;
				o_araddr  <= ~a;
			end
			if (i_rvalid && o_rready) begin
				d = i_rdata;
				r = i_rresp;
				o_rready <= 1'b0;
				break;
			end
		end
	endtask
endmodule

/* File: bench/exec_core_checker.sv */
`include "core_ops_map.vh"

module exec_core_checker #(
	parameter DMEM_AW = 6
) (
	input wire        i_core_clk,
	input wire        i_resetn,
	input wire        i_awvalid,
	input wire        o_awready,
	input wire        i_wvalid,
	input wire        o_wready,
	input wire [1:0]  o_bresp,
	input wire        o_bvalid,
	input wire        i_bready,
	input wire [11:0] i_araddr,
	input wire        i_arvalid,
	input wire        o_arready,
	input wire [31:0] o_rdata,
	input wire [1:0]  o_rresp,
	input wire        o_rvalid,
	input wire        i_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [11:0] ar_r;
	// last accepted read address, to know what rdata means
	always @(posedge i_core_clk) begin
		if (!i_resetn)
			ar_r <= 12'h000;
		else if (i_arvalid && o_arready)
			ar_r <= i_araddr;
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	a_b_after_two: assert property (i_awvalid && o_awready && i_wvalid &&
		o_wready |=> !o_bvalid ##1 o_bvalid) else $error("late bvalid");
	a_r_after_two: assert property (i_arvalid && o_arready
		|=> !o_rvalid ##1 o_rvalid) else $error("late rvalid");
	a_b_holds: assert property (o_bvalid && !i_bready
		|=> o_bvalid && $stable(o_bresp)) else $error("bvalid dropped");
	a_r_holds: assert property (o_rvalid && !i_rready
		|=> o_rvalid && $stable(o_rdata)) else $error("rvalid dropped");
	a_b_clears: assert property (o_bvalid && i_bready |=> !o_bvalid)
		else $error("bvalid stuck");
	a_ar_drops: assert property (i_arvalid && o_arready |=> !o_arready)
		else $error("arready stuck");
	a_decerr_zero: assert property (o_rvalid && o_rresp == `RESP_DECERR
		|-> o_rdata == 32'h0) else $error("decerr with data");
	a_taken_two: assert property (
		o_rvalid && ar_r == `OFS_STATUS && o_rdata[16]
		|-> o_rdata[9:8] == 2'h2) else $error("taken branch not 2 cycles");
	a_flags_byte: assert property (o_rvalid && ar_r == `OFS_FLAGS
		|-> o_rdata[31:8] == 24'h0) else $error("flags upper bits set");
	// main traffic kinds
	c_slverr: cover property (o_bvalid && o_bresp == `RESP_SLVERR);
	c_decerr: cover property (o_rvalid && o_rresp == `RESP_DECERR);
	c_taken: cover property (o_rvalid && ar_r == `OFS_STATUS && o_rdata[16]);
endmodule

bind exec_core exec_core_checker #(.DMEM_AW(DMEM_AW)) exec_core_checker_i (
	.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_awvalid(i_awvalid),
	.o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
	.o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
	.i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
	.o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
	.i_rready(i_rready));

/* File: bench/test_exec_core.sv */
`include "core_ops_map.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error at %0t: got %h, expected %h", $time, g, e); end end

module test_exec_core;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_core_clk = 1'b0;
	logic        i_resetn   = 1'b0;
	wire  [11:0] awaddr, araddr;
	wire  [31:0] wdata, rdata;
	wire  [3:0]  wstrb;
	wire  [1:0]  bresp, rresp;
	wire         awvalid, awready, wvalid, wready, bvalid, bready;
	wire         arvalid, arready, rvalid, rready;
	int          error_cnt = 0;
	int          n_checks  = 0;
	logic [31:0] d;
	logic [1:0]  r;
	always #10 i_core_clk = ~i_core_clk;
	exec_core #(.DMEM_AW(6)) exec_core_i (.i_core_clk(i_core_clk),
		.i_resetn(i_resetn), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
		.i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
	axil_host axil_host_i (.i_core_clk(i_core_clk), .i_awready(awready),
		.i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid),
		.i_arready(arready), .i_rdata(rdata), .i_rresp(rresp),
		.i_rvalid(rvalid), .o_awaddr(awaddr), .o_awvalid(awvalid),
		.o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
		.o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid),
		.o_rready(rready));
	function automatic [11:0] ga(input [4:0] n);
		ga = 12'h080 + {n, 2'b00};
	endfunction
	task automatic wreg(input [11:0] a, input [31:0] v);
		axil_host_i.wr(a, v, 4'hF, r);
		`CHK(r, `RESP_OKAY)
	endtask
	task automatic chk_rd(input [11:0] a, input [31:0] e);
		axil_host_i.rd(a, d, r);
		`CHK(d, e)
	endtask
	// status read cannot finish before execution ends, leaves it in d
	task automatic run(input [5:0] op, input [4:0] rd, input [4:0] rr,
		input [15:0] imm);
		wreg(`OFS_INSTR, {op, rd, rr, imm});
		axil_host_i.rd(`OFS_STATUS, d, r);
	endtask
	task automatic t_reset;
		chk_rd(`OFS_FLAGS, 32'h0);
		chk_rd(`OFS_PC, 32'h0);
		axil_host_i.rd(12'h040, d, r);
		`CHK({r, d}, {`RESP_DECERR, 32'h0})
		axil_host_i.wr(12'h040, 32'h1, 4'hF, r);
		`CHK(r, `RESP_DECERR)
		axil_host_i.wr(`OFS_INSTR, {`OP_LOAD_CONST, 26'h1}, 4'h1, r);
		`CHK(r, `RESP_SLVERR)
	endtask
	task automatic t_branch;
		logic [7:0] fl [6] = '{8'h00, 8'h08, 8'h80, 8'h00, 8'h00, 8'h80};
		for (int i = 0; i < 6; i++) begin
			wreg(`OFS_PC, 32'h0010);
			wreg(`OFS_FLAGS, {24'h0, fl[i]});
			run(6'h01 + 6'(i / 2), 5'h0, 5'h0, 16'hFFFC);
			`CHK({d[16], d[9:8]}, i[0] ? 3'h1 : 3'h6)
			chk_rd(`OFS_PC, i[0] ? 32'h0011 : 32'h000D);
			chk_rd(`OFS_FLAGS, {24'h0, fl[i]});
		end
	endtask
	task automatic t_io;
		wreg(`OFS_FLAGS, 32'h0);
		wreg(12'h114, 32'h5A);
		run(`OP_IO_SET, 5'h0, 5'h0, 16'h0028);
		`CHK(d[9:8], 2'h2)
		chk_rd(12'h114, 32'h5B);
		run(`OP_IO_CLR, 5'h0, 5'h0, 16'h002B);
		chk_rd(12'h114, 32'h53);
		chk_rd(`OFS_FLAGS, 32'h0);
		// unaligned read of a live register must still answer zero
		axil_host_i.rd(12'h115, d, r);
		`CHK({r, d}, {`RESP_DECERR, 32'h0})
	endtask
	// C in and S, H set: shifts must leave S and H alone
	task automatic t_shift;
		logic [7:0] res [5] = '{8'h02, 8'h40, 8'h03, 8'hC0, 8'hC0};
		for (int i = 0; i < 5; i++) begin
			wreg(ga(1), 32'h81);
			wreg(`OFS_FLAGS, 32'h31);
			run(`OP_SHL + 6'(i), 5'h1, 5'h0, 16'h0);
			`CHK(d[9:8], 2'h1)
			chk_rd(ga(1), {24'h0, res[i]});
			chk_rd(`OFS_FLAGS, res[i][7] ? 32'h35 : 32'h39);
		end
	endtask
	task automatic t_move;
		wreg(ga(2), 32'h3C);
		wreg(`OFS_FLAGS, 32'h5A);
		run(`OP_SWAP, 5'h2, 5'h0, 16'h0);
		chk_rd(ga(2), 32'hC3);
		chk_rd(`OFS_FLAGS, 32'h5A);
		wreg(`OFS_FLAGS, 32'h0);
		wreg(ga(3), 32'h10);
		run(`OP_BIT_TO_T, 5'h0, 5'h3, 16'h4);
		chk_rd(`OFS_FLAGS, 32'h40);
		run(`OP_T_TO_BIT, 5'h4, 5'h0, 16'h6);
		chk_rd(ga(4), 32'h40);
		run(`OP_LOAD_CONST, 5'h6, 5'h0, 16'hA5);
		run(`OP_COPY, 5'h7, 5'h6, 16'h0);
		chk_rd(ga(7), 32'hA5);
		wreg(ga(8), 32'h11);
		wreg(ga(9), 32'h22);
		run(`OP_COPY_PAIR, 5'hA, 5'h8, 16'h0);
		chk_rd(ga(10), 32'h11);
		chk_rd(ga(11), 32'h22);
		chk_rd(`OFS_FLAGS, 32'h40);
	endtask
	task automatic t_flags;
		for (int b = 0; b < 8; b++) begin
			wreg(`OFS_FLAGS, 32'h00);
			run(`OP_FLAG_SET, 5'h0, 5'h0, 16'(b));
			chk_rd(`OFS_FLAGS, 32'h1 << b);
			wreg(`OFS_FLAGS, 32'hFF);
			run(`OP_FLAG_CLR, 5'h0, 5'h0, 16'(b));
			chk_rd(`OFS_FLAGS, 32'hFF ^ (32'h1 << b));
		end
	endtask
	// X starts at 0 so the pre-decrement wraps to the top byte
	task automatic t_loads;
		logic [5:0]  op [7] = '{6'h22, 6'h21, 6'h20, 6'h24, 6'h25, 6'h26,
			6'h27};
		logic [7:0]  dv [7] = '{8'h77, 8'h77, 8'h66, 8'h55, 8'h55, 8'h55,
			8'h44};
		logic [15:0] pv [7] = '{16'hFFFF, 16'h0, 16'h0, 16'h1, 16'h2, 16'h1,
			16'h1};
		wreg(12'h2FC, 32'h77);
		wreg(12'h200, 32'h66);
		wreg(12'h204, 32'h55);
		wreg(12'h214, 32'h44);
		wreg(ga(28), 32'h1);
		wreg(`OFS_FLAGS, 32'h0);
		for (int i = 0; i < 7; i++) begin
			run(op[i], 5'h1, 5'h0, 16'h4);
			`CHK(d[9:8], 2'h2)
			chk_rd(ga(1), {24'h0, dv[i]});
			chk_rd(ga(i < 3 ? 5'd26 : 5'd28), {24'h0, pv[i][7:0]});
			chk_rd(ga(i < 3 ? 5'd27 : 5'd29), {24'h0, pv[i][15:8]});
		end
		chk_rd(`OFS_FLAGS, 32'h0);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// about a thousand bus cycles expected; twenty times that is a hang
	initial begin
		#400us;
		error_cnt++;
		complete_run;
	end
	initial begin
		repeat (3) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		@(posedge i_core_clk);
		t_reset;
		t_branch;
		t_io;
		t_shift;
		t_move;
		t_flags;
		t_loads;
		complete_run;
	end
endmodule

/* File: hw/axil_port.v */
`include "core_ops_map.vh"

module axil_port #(
	parameter AW = 12
) (
	input  wire          i_core_clk,
	input  wire          i_resetn,
	input  wire [AW-1:0] i_awaddr,
	input  wire          i_awvalid,
	output reg           o_awready,
	input  wire [31:0]   i_wdata,
	input  wire [3:0]    i_wstrb,
	input  wire          i_wvalid,
	output reg           o_wready,
	output reg  [1:0]    o_bresp,
	output reg           o_bvalid,
	input  wire          i_bready,
	input  wire [AW-1:0] i_araddr,
	input  wire          i_arvalid,
	output reg           o_arready,
	output reg  [31:0]   o_rdata,
	output reg  [1:0]    o_rresp,
	output reg           o_rvalid,
	input  wire          i_rready,
	output wire          o_wr_en,
	output reg  [AW-1:0] o_wr_addr,
	output reg  [31:0]   o_wr_data,
	output reg  [3:0]    o_wr_strb,
	input  wire [1:0]    i_wr_resp,
	output reg  [AW-1:0] o_rd_addr,
	input  wire [31:0]   i_rd_data,
	input  wire [1:0]    i_rd_resp
);
	reg aw_ok_r;
	reg w_ok_r;
	reg rd_pend_r;

	// one pulse once both halves of a write are held
	assign o_wr_en = aw_ok_r & w_ok_r & ~o_bvalid;

	// address and data are latched independently, any order
	always @(posedge i_core_clk) begin
		if (!i_resetn) begin
			aw_ok_r   <= 1'b0;
			w_ok_r    <= 1'b0;
			rd_pend_r <= 1'b0;
			o_awready <= 1'b0;
			o_wready  <= 1'b0;
			o_arready <= 1'b0;
			o_bvalid  <= 1'b0;
			o_bresp   <= `RESP_OKAY;
			o_rvalid  <= 1'b0;
			o_rresp   <= `RESP_OKAY;
			o_rdata   <= 32'h00000000;
			o_wr_addr <= {AW{1'b0}};
			o_wr_data <= 32'h00000000;
			o_wr_strb <= 4'h0;
			o_rd_addr <= {AW{1'b0}};
		end else begin
			o_awready <= ~(aw_ok_r | (i_awvalid & o_awready));
			o_wready  <= ~(w_ok_r | (i_wvalid & o_wready));
			o_arready <= ~(rd_pend_r | o_rvalid | (i_arvalid & o_arready));
			if (i_awvalid && o_awready) begin
				aw_ok_r   <= 1'b1;
				o_wr_addr <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_ok_r    <= 1'b1;
				o_wr_data <= i_wdata;
				o_wr_strb <= i_wstrb;
			end
			if (o_wr_en) begin
				o_bvalid <= 1'b1;
				o_bresp  <= i_wr_resp;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
				aw_ok_r  <= 1'b0;
				w_ok_r   <= 1'b0;
			end
			if (i_arvalid && o_arready) begin
				o_rd_addr <= i_araddr;
				rd_pend_r <= 1'b1;
			end
			if (rd_pend_r) begin
				o_rdata   <= i_rd_data;
				o_rresp   <= i_rd_resp;
				o_rvalid  <= 1'b1;
				rd_pend_r <= 1'b0;
			end
			if (o_rvalid && i_rready)
				o_rvalid <= 1'b0;
		end
	end
endmodule

/* File: hw/exec_core.v */
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`include "core_ops_map.vh"

module exec_core #(
	parameter DMEM_AW = 6
) (
	input  wire        i_core_clk,
	input  wire        i_resetn,
	input  wire [11:0] i_awaddr,
	input  wire        i_awvalid,
	output wire        o_awready,
	input  wire [31:0] i_wdata,
	input  wire [3:0]  i_wstrb,
	input  wire        i_wvalid,
	output wire        o_wready,
	output wire [1:0]  o_bresp,
	output wire        o_bvalid,
	input  wire        i_bready,
	input  wire [11:0] i_araddr,
	input  wire        i_arvalid,
	output wire        o_arready,
	output wire [31:0] o_rdata,
	output wire [1:0]  o_rresp,
	output wire        o_rvalid,
	input  wire        i_rready
);
	localparam S_IDLE = 2'h0;
	localparam S_EXEC = 2'h1;
	localparam S_FIN  = 2'h2;
	localparam DEPTH  = 1 << DMEM_AW;

	// architectural state
	reg  [7:0]  gpr_r [0:31];
	reg  [7:0]  io_r [0:31];
	reg  [7:0]  dmem_r [0:DEPTH-1];
	reg  [7:0]  flags_r;
	reg  [15:0] pc_r;
	reg  [1:0]  state_r;
	reg  [31:0] instr_r;
	reg  [15:0] addr_r;
	reg         taken_r;
	reg  [1:0]  cycles_r;
	integer     i;

	// bus side
	wire        wr_en;
	wire [11:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0]  wr_strb;
	reg  [1:0]  wr_resp;
	wire [11:0] rd_addr;
	reg  [31:0] rd_data;
	reg  [1:0]  rd_resp;

	// decoded instruction fields
	wire [5:0]  op      = instr_r[`F_OP];
	wire [4:0]  rd      = instr_r[`F_RD];
	wire [4:0]  rr      = instr_r[`F_RR];
	wire [2:0]  bsel    = instr_r[`F_BIT];
	wire [4:0]  io_idx  = instr_r[`F_IO];
	wire [15:0] imm     = instr_r[`F_IMM];
	wire [7:0]  rd_val  = gpr_r[rd];
	wire [7:0]  rr_val  = gpr_r[rr];
	wire [4:0]  rd_even = {rd[4:1], 1'b0};
	wire [4:0]  rd_odd  = {rd[4:1], 1'b1};
	wire [4:0]  rr_even = {rr[4:1], 1'b0};
	wire [4:0]  rr_odd  = {rr[4:1], 1'b1};
	wire        busy    = (state_r != S_IDLE);

	wire [7:0]  sh_res;
	wire        sh_c;
	wire        sh_z;
	wire        sh_n;
	wire        sh_v;

	// loads occupy opcodes 0x20..0x27; 0x23 has no addressing form
	// and runs as an unknown opcode: one cycle, pc only
	function is_load;
		input [5:0] f_op;
		begin
			is_load = (f_op[5:3] == 3'h4) &&
				(f_op[2:0] != 3'h3);
		end
	endfunction

	// low two opcode bits pick the addressing form
	function [1:0] load_form;
		input [5:0] f_op;
		begin
			load_form = f_op[1:0];
		end
	endfunction

	// every mapped address is word aligned in a known region
	function mapped;
		input [11:0] a;
		begin
			mapped = (a[1:0] == 2'h0) &&
				((a[11:7] == `RGN_GPR) || (a[11:7] == `RGN_IO) ||
				(a[11:8] == `RGN_DMEM) || (a == `OFS_INSTR) ||
				(a == `OFS_STATUS) || (a == `OFS_PC) ||
				(a == `OFS_FLAGS));
		end
	endfunction

	// pointer selection and effective address
	wire        use_y    = op[2] | (op == `OP_LOAD_Y_DISP);
	wire [4:0]  ptr_lo   = use_y ? `PTR_Y_LO : `PTR_X_LO;
	wire [15:0] ptr_base = {gpr_r[ptr_lo + 5'h01], gpr_r[ptr_lo]};
	wire        predec   = (load_form(op) == 2'h2);
	wire        postinc  = (load_form(op) == 2'h1);
	wire        displ    = (op == `OP_LOAD_Y_DISP);
	wire [15:0] ptr_dec  = ptr_base - 16'h0001;
	wire [15:0] ptr_inc  = ptr_base + 16'h0001;
	wire [15:0] eff_addr = predec ? ptr_dec :
		displ ? ptr_base + {10'h000, imm[5:0]} : ptr_base;

	// branch condition from V or I
	wire br_take = (op == `OP_BR_OVF_CLR) ? ~flags_r[`FL_V] :
		(op == `OP_BR_INT_ON) ? flags_r[`FL_I] :
		~flags_r[`FL_I];

	axil_port #(
		.AW(12)
	) u_bus (
		.i_core_clk (i_core_clk),
		.i_resetn   (i_resetn),
		.i_awaddr   (i_awaddr),
		.i_awvalid  (i_awvalid),
		.o_awready  (o_awready),
		.i_wdata    (i_wdata),
		.i_wstrb    (i_wstrb),
		.i_wvalid   (i_wvalid),
		.o_wready   (o_wready),
		.o_bresp    (o_bresp),
		.o_bvalid   (o_bvalid),
		.i_bready   (i_bready),
		.i_araddr   (i_araddr),
		.i_arvalid  (i_arvalid),
		.o_arready  (o_arready),
		.o_rdata    (o_rdata),
		.o_rresp    (o_rresp),
		.o_rvalid   (o_rvalid),
		.i_rready   (i_rready),
		.o_wr_en    (wr_en),
		.o_wr_addr  (wr_addr),
		.o_wr_data  (wr_data),
		.o_wr_strb  (wr_strb),
		.i_wr_resp  (wr_resp),
		.o_rd_addr  (rd_addr),
		.i_rd_data  (rd_data),
		.i_rd_resp  (rd_resp)
	);

	shift_unit u_shift (
		.i_sel   (op[2:0]),
		.i_val   (rd_val),
		.i_carry (flags_r[`FL_C]),
		.o_res   (sh_res),
		.o_c     (sh_c),
		.o_z     (sh_z),
		.o_n     (sh_n),
		.o_v     (sh_v)
	);

	// write answer: state is frozen while an instruction runs
	always @* begin
		wr_resp = `RESP_OKAY;
		if (!mapped(wr_addr))
			wr_resp = `RESP_DECERR;
		else if (busy)
			wr_resp = `RESP_SLVERR;
		else if (wr_addr == `OFS_INSTR && wr_strb != 4'hF)
			wr_resp = `RESP_SLVERR;
	end

	// read mux; reads are harmless at any time
	// a refused read answers zero, unaligned ones included
	always @* begin
		rd_data = 32'h00000000;
		rd_resp = mapped(rd_addr) ? `RESP_OKAY : `RESP_DECERR;
		if (!mapped(rd_addr))
			rd_data = 32'h00000000;
		else if (rd_addr[11:7] == `RGN_GPR)
			rd_data = {24'h000000, gpr_r[rd_addr[6:2]]};
		else if (rd_addr[11:7] == `RGN_IO)
			rd_data = {24'h000000, io_r[rd_addr[6:2]]};
		else if (rd_addr[11:8] == `RGN_DMEM)
			rd_data = {24'h000000, dmem_r[rd_addr[DMEM_AW+1:2]]};
		else begin
			case (rd_addr)
			`OFS_INSTR:  rd_data = instr_r;
			`OFS_STATUS: rd_data = {15'h0000, taken_r, 6'h00,
				cycles_r, 7'h00, busy};
			`OFS_PC:     rd_data = {16'h0000, pc_r};
			`OFS_FLAGS:  rd_data = {24'h000000, flags_r};
			default:     rd_data = 32'h00000000;
			endcase
		end
	end

	// execution sequencer and register writes
	always @(posedge i_core_clk) begin
		if (!i_resetn) begin
			for (i = 0; i < 32; i = i + 1) begin
				gpr_r[i] <= 8'h00;
				io_r[i]  <= 8'h00;
			end
			flags_r  <= `FLAGS_RST;
			pc_r     <= `PC_RST;
			state_r  <= S_IDLE;
			instr_r  <= 32'h00000000;
			addr_r   <= 16'h0000;
			taken_r  <= 1'b0;
			cycles_r <= 2'h0;
		end else begin
			case (state_r)
			S_IDLE: ;
			S_EXEC: begin
				state_r <= S_IDLE;
				pc_r    <= pc_r + 16'h0001;
				case (op)
				`OP_BR_OVF_CLR, `OP_BR_INT_ON, `OP_BR_INT_OFF: begin
					// not taken: pc+1 from above, one cycle
					if (br_take) begin
						pc_r     <= pc_r + imm + 16'h0001;
						taken_r  <= 1'b1;
						state_r  <= S_FIN;
						cycles_r <= `CYC_LONG;
					end
				end
				`OP_IO_SET, `OP_IO_CLR: begin
					state_r  <= S_FIN;
					cycles_r <= `CYC_LONG;
				end
				`OP_SHL, `OP_SHR, `OP_ROT_L_C, `OP_ROT_R_C, `OP_SHR_S: begin
					// V leaves as N xor C for every shift kind
					gpr_r[rd]      <= sh_res;
					flags_r[`FL_C] <= sh_c;
					flags_r[`FL_Z] <= sh_z;
					flags_r[`FL_N] <= sh_n;
					flags_r[`FL_V] <= sh_v;
				end
				`OP_SWAP:
					gpr_r[rd] <= {rd_val[3:0], rd_val[7:4]};
				`OP_FLAG_SET:
					flags_r[bsel] <= 1'b1;
				`OP_FLAG_CLR:
					flags_r[bsel] <= 1'b0;
				`OP_BIT_TO_T:
					flags_r[`FL_T] <= rr_val[bsel];
				`OP_T_TO_BIT:
					gpr_r[rd][bsel] <= flags_r[`FL_T];
				`OP_COPY:
					gpr_r[rd] <= rr_val;
				`OP_COPY_PAIR: begin
					gpr_r[rd_even] <= gpr_r[rr_even];
					gpr_r[rd_odd]  <= gpr_r[rr_odd];
				end
				`OP_LOAD_CONST:
					gpr_r[rd] <= imm[7:0];
				default: begin
					if (is_load(op)) begin
						// address fixed now, memory read next cycle
						addr_r   <= eff_addr;
						state_r  <= S_FIN;
						cycles_r <= `CYC_LONG;
						if (predec) begin
							gpr_r[ptr_lo]         <= ptr_dec[7:0];
							gpr_r[ptr_lo + 5'h01] <= ptr_dec[15:8];
						end
					end
				end
				endcase
			end
			S_FIN: begin
				// a taken branch only waits here, pc is already set
				state_r <= S_IDLE;
				if (op == `OP_IO_SET)
					io_r[io_idx][bsel] <= 1'b1;
				if (op == `OP_IO_CLR)
					io_r[io_idx][bsel] <= 1'b0;
				if (is_load(op)) begin
					// high pointer bits alias onto the small memory
					gpr_r[rd] <= dmem_r[addr_r[DMEM_AW-1:0]];
					if (postinc) begin
						// pointer update wins over a load into itself
						gpr_r[ptr_lo]         <= ptr_inc[7:0];
						gpr_r[ptr_lo + 5'h01] <= ptr_inc[15:8];
					end
				end
			end
			// an unused state code falls back to idle
			default:
				state_r <= S_IDLE;
			endcase
			// software access only lands while idle
			if (wr_en && wr_resp == `RESP_OKAY) begin
				if (wr_addr[11:7] == `RGN_GPR) begin
					if (wr_strb[0])
						gpr_r[wr_addr[6:2]] <= wr_data[7:0];
				end else if (wr_addr[11:7] == `RGN_IO) begin
					if (wr_strb[0])
						io_r[wr_addr[6:2]] <= wr_data[7:0];
				end else if (wr_addr[11:8] == `RGN_DMEM) begin
					if (wr_strb[0])
						dmem_r[wr_addr[DMEM_AW+1:2]] <= wr_data[7:0];
				end else if (wr_addr == `OFS_INSTR) begin
					instr_r  <= wr_data;
					state_r  <= S_EXEC;
					taken_r  <= 1'b0;
					cycles_r <= `CYC_SHORT;
				end else if (wr_addr == `OFS_PC) begin
					// only byte lanes 0 and 1 exist in pc
					if (wr_strb[0])
						pc_r[7:0] <= wr_data[7:0];
					if (wr_strb[1])
						pc_r[15:8] <= wr_data[15:8];
				end else if (wr_addr == `OFS_FLAGS) begin
					if (wr_strb[0])
						flags_r <= wr_data[7:0];
				end
			end
		end
	end
endmodule

/* File: hw/shift_unit.v */
`include "core_ops_map.vh"

module shift_unit (
	input  wire [2:0] i_sel,
	input  wire [7:0] i_val,
	input  wire       i_carry,
	output reg  [7:0] o_res,
	output reg        o_c,
	output wire       o_z,
	output wire       o_n,
	output wire       o_v
);
	// result and carry out per shift kind
	always @* begin
		o_res = {i_val[6:0], 1'b0};
		o_c   = i_val[7];
		case (i_sel)
		`SH_RIGHT: begin
			o_res = {1'b0, i_val[7:1]};
			o_c   = i_val[0];
		end
		`SH_ROT_L: begin
			o_res = {i_val[6:0], i_carry};
			o_c   = i_val[7];
		end
		`SH_ROT_R: begin
			o_res = {i_carry, i_val[7:1]};
			o_c   = i_val[0];
		end
		`SH_RIGHT_S: begin
			o_res = {i_val[7], i_val[7:1]};
			o_c   = i_val[0];
		end
		default: ;
		endcase
	end

	// overflow of a shift is sign xor carry out
	assign o_z = (o_res == 8'h00);
	assign o_n = o_res[7];
	assign o_v = o_res[7] ^ o_c;
endmodule

/* File: inc/core_ops_map.vh */
`ifndef CORE_OPS_MAP_VH
`define CORE_OPS_MAP_VH
// register byte offsets
`define OFS_INSTR      12'h000
`define OFS_STATUS     12'h004
`define OFS_PC         12'h008
`define OFS_FLAGS      12'h00C
`define RGN_GPR        5'h01
`define RGN_IO         5'h02
`define RGN_DMEM       4'h2
// instruction word fields
`define F_OP           31:26
`define F_RD           25:21
`define F_RR           20:16
`define F_BIT          2:0
`define F_IO           7:3
`define F_IMM          15:0
// opcodes
`define OP_BR_OVF_CLR  6'h01
`define OP_BR_INT_ON   6'h02
`define OP_BR_INT_OFF  6'h03
`define OP_IO_SET      6'h04
`define OP_IO_CLR      6'h05
`define OP_SHL         6'h08
`define OP_SHR         6'h09
`define OP_ROT_L_C     6'h0A
`define OP_ROT_R_C     6'h0B
`define OP_SHR_S       6'h0C
`define OP_SWAP        6'h0D
`define OP_FLAG_SET    6'h10
`define OP_FLAG_CLR    6'h11
`define OP_BIT_TO_T    6'h12
`define OP_T_TO_BIT    6'h13
`define OP_COPY        6'h18
`define OP_COPY_PAIR   6'h19
`define OP_LOAD_CONST  6'h1A
`define OP_LOAD_X      6'h20
`define OP_LOAD_Y_DISP 6'h27
// shifter selects (low bits of the shift opcodes)
`define SH_LEFT        3'h0
`define SH_RIGHT       3'h1
`define SH_ROT_L       3'h2
`define SH_ROT_R       3'h3
`define SH_RIGHT_S     3'h4
// status flag positions
`define FL_C           0
`define FL_Z           1
`define FL_N           2
`define FL_V           3
`define FL_S           4
`define FL_H           5
`define FL_T           6
`define FL_I           7
`define FLAGS_RST      8'h00
`define PC_RST         16'h0000
`define CYC_SHORT      2'h1
`define CYC_LONG       2'h2
`define PTR_X_LO       5'h1A
`define PTR_Y_LO       5'h1C
// bus responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define RESP_DECERR    2'h3
`endif
